/* rtl/actl_consts.vh */
// constants of the codec tdm link: clock ratios, frame layout, slot sizes, reset timing
// assumes a 20 MHz system clock and a bit clock divided down from it
`ifndef ACTL_CONSTS_VH
`define ACTL_CONSTS_VH

// system clock in MHz
`define ACTL_CLK_MHZ 20
// nominal bit clock and frame rate of the link
`define ACTL_BCLK_NOM_HZ 24000000
`define ACTL_FRAME_HZ 48000
// bit clock periods in one frame
`define ACTL_FRAME_BCLKS (`ACTL_BCLK_NOM_HZ / `ACTL_FRAME_HZ)
`define ACTL_LAST_BIT 9'h1F3
// system clocks per bit clock period, and the phase points inside it
`define ACTL_DIV_W 3
`define ACTL_DIV_LAST 3'h7
`define ACTL_DIV_HALF 3'h3
`define ACTL_DIV_HIGH 3'h4
`define ACTL_DIV_SAMPLE 3'h6
// frame sync marker and stream tag placement, in bit clock periods
`define ACTL_SYNC_MARK 9'h004
`define ACTL_TAG_END 9'h008
`define ACTL_TAG_W 4
// payload word width and the span of whole words in a frame
`define ACTL_WORD_W 16
`define ACTL_SLOT_MASK 9'h00F
`define ACTL_TX_SLOT_MASK 9'h007
`define ACTL_WORD_END 9'h1F0
`define ACTL_BIT_W 9
// codec reset hold, which is also the strap window on the serial out pin
`define ACTL_STRAP_NS 1000
`define ACTL_STRAP_CYC ((`ACTL_STRAP_NS * `ACTL_CLK_MHZ + 999) / 1000)
`define ACTL_STRAP_W 5

`endif

/* rtl/actl_buf2.v */
// two-entry buffer with valid and ready on both sides
// assumes write and read sides run on the same clock
module actl_buf2 (
	input wire clk_in, // system clock
	input wire rst_n_in, // async reset, active low
	input wire [15:0] wr_data_in, // word to store
	input wire wr_valid_in, // word offered
	output wire wr_ready_out, // space free
	output wire [15:0] rd_data_out, // head word
	output wire rd_valid_out, // head word present
	input wire rd_ready_in // head word taken
);

reg [15:0] mem0_ff;
reg [15:0] mem1_ff;
reg [1:0] cnt_ff;
reg wr_ready_ff;
reg rd_valid_ff;
reg [1:0] nxt_cnt;
wire push;
wire pop;

assign push = wr_valid_in & wr_ready_ff;
assign pop = rd_ready_in & rd_valid_ff;
assign wr_ready_out = wr_ready_ff;
assign rd_valid_out = rd_valid_ff;
assign rd_data_out = mem0_ff;

always @* begin
	nxt_cnt = cnt_ff;
	if (push && !pop)
		nxt_cnt = cnt_ff + 2'h1;
	else if (pop && !push)
		nxt_cnt = cnt_ff - 2'h1;
end

always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		mem0_ff <= 16'h0000;
		mem1_ff <= 16'h0000;
		cnt_ff <= 2'h0;
		wr_ready_ff <= 1'b0;
		rd_valid_ff <= 1'b0;
	end else begin
		cnt_ff <= nxt_cnt;
		wr_ready_ff <= (nxt_cnt != 2'h2);
		rd_valid_ff <= (nxt_cnt != 2'h0);
		if (pop) begin
			if (cnt_ff == 2'h2)
				mem0_ff <= mem1_ff;
			else if (push)
				mem0_ff <= wr_data_in;
			if (push && cnt_ff == 2'h2)
				mem1_ff <= wr_data_in;
		end else if (push) begin
			if (cnt_ff == 2'h0)
				mem0_ff <= wr_data_in;
			else
				mem1_ff <= wr_data_in;
		end
	end
end

endmodule // actl_buf2

/* rtl/actl_tdm_link.v */
// host end of the tdm serial link to up to three audio codecs
// assumes codecs launch serial in data on the bit clock rising edge and align to frame sync
//
// Contract
// - the block drives an active-low codec link reset that is the master reset of every codec.
// - frame sync recurs at a fixed 5 kHz, one frame every 500 bit clock periods.
// - frame sync also carries the stream number, sent after the frame marker.
// - the block itself makes the link bit clock, 2.5 MHz, divided by eight from its own clock.
// - serial out data change on both bit clock edges, two bits per period.
// - serial in data carry one bit per bit clock period and are captured once per period.
// - there are three separate serial data inputs, one per codec.
// - only the high-definition codec protocol is served; no older codec mode exists.
// - serial out is released during codec reset and its level is caught there as a strap.
`include "actl_consts.vh"

module actl_tdm_link (
	input wire clk_in, // system clock, 20 MHz
	input wire rst_n_in, // async reset, active low
	input wire link_en_in, // link allowed to leave reset
	input wire [3:0] stream_num_in, // stream number for the next frame
	input wire [15:0] tx_data_in, // outgoing word
	input wire tx_valid_in, // outgoing word offered
	output wire tx_ready_out, // outgoing word accepted
	output reg [47:0] rx_data_out, // codec 2,1,0 words
	output reg rx_valid_out, // one-cycle pulse, new words
	output reg strap_out, // serial out level caught in reset
	output reg codec_link_reset_n_out, // codec master reset, active low
	output reg link_bit_clock_out, // link bit clock
	output reg frame_sync_out, // frame sync
	output reg serial_out_to_codecs_out, // serial out, driven value
	output reg serial_out_to_codecs_oe_out, // serial out, drive enable
	input wire serial_out_to_codecs_in, // serial out, pin level
	input wire [2:0] serial_in_from_codecs_in // serial in, one per codec
);

localparam ST_HOLD = 2'b01;
localparam ST_RUN = 2'b10;

//////////////////////////////////////////////////////////////////////////////
// helpers

function word_start;
	input [`ACTL_BIT_W-1:0] idx;
	input [`ACTL_BIT_W-1:0] mask;
	begin
		word_start = ((idx & mask) == 9'h000) && (idx < `ACTL_WORD_END);
	end
endfunction

function word_last;
	input [`ACTL_BIT_W-1:0] idx;
	begin
		word_last = ((idx & `ACTL_SLOT_MASK) == `ACTL_SLOT_MASK) && (idx < `ACTL_WORD_END);
	end
endfunction

// next divider phase; the bit clock output looks one phase ahead so it lines up with the divider
function [`ACTL_DIV_W-1:0] div_next;
	input [`ACTL_DIV_W-1:0] d;
	begin
		div_next = d + 3'h1;
	end
endfunction

function [15:0] shl_word;
	input [15:0] w;
	begin
		shl_word = {w[14:0], 1'b0};
	end
endfunction

// one new bit into each codec's word, codec 0 in the low word
function [47:0] rx_shift;
	input [47:0] sh;
	input [2:0] bits;
	integer k;
	begin
		rx_shift = sh;
		for (k = 0; k < 3; k = k + 1)
			rx_shift[k*16 +: 16] = {sh[k*16 +: 15], bits[k]};
	end
endfunction

//////////////////////////////////////////////////////////////////////////////
// declarations

reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [`ACTL_STRAP_W-1:0] strap_cnt_ff;
reg [`ACTL_DIV_W-1:0] div_ff;
reg [`ACTL_BIT_W-1:0] bit_idx_ff;
reg [`ACTL_BIT_W-1:0] nxt_bit_idx;
reg [`ACTL_TAG_W-1:0] tag_ff;
reg [15:0] tx_sh_ff;
reg [47:0] rx_sh_ff;
reg [2:0] sdi_s1_ff;
reg [2:0] sdi_s2_ff;
reg sdo_s1_ff;
reg sdo_s2_ff;
reg nxt_sync;
wire strap_done;
wire leave_hold;
wire stay_run;
wire run;
wire rise_evt;
wire fall_evt;
wire load_evt;
wire [15:0] buf_data;
wire buf_valid;
wire buf_pop;
wire [`ACTL_BIT_W-1:0] tag_pos;

assign run = state_ff[1];
assign rise_evt = (div_ff == `ACTL_DIV_LAST);
assign fall_evt = (div_ff == `ACTL_DIV_HALF);
assign load_evt = run && rise_evt && word_start(nxt_bit_idx, `ACTL_TX_SLOT_MASK);
assign buf_pop = load_evt;
assign tag_pos = nxt_bit_idx - `ACTL_SYNC_MARK;
// state decodes shared by the reset sequence and the serial out enable
assign strap_done = (strap_cnt_ff == `ACTL_STRAP_CYC);
assign leave_hold = (state_ff == ST_HOLD) && (nxt_state == ST_RUN);
assign stay_run = run && (nxt_state == ST_RUN);

//////////////////////////////////////////////////////////////////////////////
// outgoing word buffer

actl_buf2 actl_buf2_i (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.wr_data_in(tx_data_in),
	.wr_valid_in(tx_valid_in),
	.wr_ready_out(tx_ready_out),
	.rd_data_out(buf_data),
	.rd_valid_out(buf_valid),
	.rd_ready_in(buf_pop)
);

//////////////////////////////////////////////////////////////////////////////
// pin synchronisers

// serial in pins, two flops each
always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		sdi_s1_ff <= 3'h0;
		sdi_s2_ff <= 3'h0;
	end else begin
		sdi_s1_ff <= serial_in_from_codecs_in;
		sdi_s2_ff <= sdi_s1_ff;
	end
end

// serial out pin read back for the strap
always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		sdo_s1_ff <= 1'b0;
		sdo_s2_ff <= 1'b0;
	end else begin
		sdo_s1_ff <= serial_out_to_codecs_in;
		sdo_s2_ff <= sdo_s1_ff;
	end
end

//////////////////////////////////////////////////////////////////////////////
// reset and strap sequence

// codecs stay in reset for the whole strap window, then leave it only while the link is allowed
always @* begin
	nxt_state = state_ff;
	case (state_ff)
		ST_HOLD: begin
			if (link_en_in && strap_done)
				nxt_state = ST_RUN;
		end
		ST_RUN: begin
			if (!link_en_in)
				nxt_state = ST_HOLD;
		end
		default: nxt_state = ST_HOLD;
	endcase
end

always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		state_ff <= ST_HOLD;
		strap_cnt_ff <= 5'h00;
		strap_out <= 1'b0;
		codec_link_reset_n_out <= 1'b0;
	end else begin
		state_ff <= nxt_state;
		if (state_ff != ST_HOLD)
			strap_cnt_ff <= 5'h00;
		else if (!strap_done)
			strap_cnt_ff <= strap_cnt_ff + 5'h01;
		if (leave_hold)
			strap_out <= sdo_s2_ff;
		codec_link_reset_n_out <= (nxt_state == ST_RUN);
	end
end

//////////////////////////////////////////////////////////////////////////////
// bit clock and frame timing

always @* begin
	nxt_bit_idx = bit_idx_ff;
	if (rise_evt) begin
		if (bit_idx_ff == `ACTL_LAST_BIT)
			nxt_bit_idx = 9'h000;
		else
			nxt_bit_idx = bit_idx_ff + 9'h001;
	end
end

// marker high for the first periods, then the stream tag msb first
always @* begin
	nxt_sync = 1'b0;
	if (nxt_bit_idx < `ACTL_SYNC_MARK)
		nxt_sync = 1'b1;
	else if (nxt_bit_idx < `ACTL_TAG_END)
		nxt_sync = tag_ff[`ACTL_TAG_W-1-tag_pos[1:0]];
end

// bit clock runs from reset on; the divider starts in the low phase so the first high phase is whole
always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		div_ff <= `ACTL_DIV_LAST;
		link_bit_clock_out <= 1'b0;
	end else begin
		div_ff <= div_next(div_ff);
		link_bit_clock_out <= (div_next(div_ff) < `ACTL_DIV_HIGH);
	end
end

always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		bit_idx_ff <= `ACTL_LAST_BIT;
		frame_sync_out <= 1'b0;
		tag_ff <= 4'h0;
	end else begin
		if (!run) begin
			bit_idx_ff <= `ACTL_LAST_BIT;
			frame_sync_out <= 1'b0;
		end else if (rise_evt) begin
			bit_idx_ff <= nxt_bit_idx;
			frame_sync_out <= nxt_sync;
			if (nxt_bit_idx == 9'h000)
				tag_ff <= stream_num_in;
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// serial out, two bits per bit clock period

always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		tx_sh_ff <= 16'h0000;
		serial_out_to_codecs_out <= 1'b0;
		serial_out_to_codecs_oe_out <= 1'b0;
	end else begin
		// released on the edge the codec reset drops, so the strap pin is never driven in reset
		serial_out_to_codecs_oe_out <= stay_run;
		if (!run) begin
			tx_sh_ff <= 16'h0000;
			serial_out_to_codecs_out <= 1'b0;
		end else if (load_evt) begin
			if (buf_valid) begin
				serial_out_to_codecs_out <= buf_data[15];
				tx_sh_ff <= shl_word(buf_data);
			end else begin
				serial_out_to_codecs_out <= 1'b0;
				tx_sh_ff <= 16'h0000;
			end
		end else if (rise_evt || fall_evt) begin
			serial_out_to_codecs_out <= tx_sh_ff[15];
			tx_sh_ff <= shl_word(tx_sh_ff);
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// serial in, one bit per period from each codec

// sample point sits two clocks after the bit clock falls, covering the synchroniser delay
always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		rx_sh_ff <= 48'h000000000000;
		rx_data_out <= 48'h000000000000;
		rx_valid_out <= 1'b0;
	end else begin
		rx_valid_out <= 1'b0;
		if (run && div_ff == `ACTL_DIV_SAMPLE) begin
			rx_sh_ff <= rx_shift(rx_sh_ff, sdi_s2_ff);
			if (word_last(bit_idx_ff)) begin
				rx_data_out <= rx_shift(rx_sh_ff, sdi_s2_ff);
				rx_valid_out <= 1'b1;
			end
		end
	end
end

endmodule // actl_tdm_link

/* testbench/actl_tdm_link_properties.sv */
// checker on the ports of the codec link block
// assumes it is bound to every actl_tdm_link instance
module actl_tdm_link_chk (
	input wire clk_in, // system clock
	input wire rst_n_in, // reset, active low
	input wire codec_link_reset_n_out, // codec reset
	input wire link_bit_clock_out, // bit clock
	input wire frame_sync_out, // frame sync
	input wire serial_out_to_codecs_out, // serial out value
	input wire serial_out_to_codecs_oe_out, // serial out enable
	input wire rx_valid_out // received words pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_oe_in_reset: assert property (
		!codec_link_reset_n_out |-> !serial_out_to_codecs_oe_out) else $error("serial out driven in reset");
	a_oe_after_hold: assert property (
		$rose(codec_link_reset_n_out) |=> serial_out_to_codecs_oe_out) else $error("serial out not driven");
	a_hold_length: assert property (
		$fell(codec_link_reset_n_out) |-> !codec_link_reset_n_out[*8] ##12 !codec_link_reset_n_out)
		else $error("codec reset too short");
	a_bclk_shape: assert property (
		$rose(link_bit_clock_out) |-> link_bit_clock_out[*4] ##1 !link_bit_clock_out[*4] ##1 link_bit_clock_out)
		else $error("bit clock shape wrong");
	a_sync_on_rise: assert property (
		$changed(frame_sync_out) && codec_link_reset_n_out |-> $rose(link_bit_clock_out))
		else $error("sync moved off a bit clock rise");
	a_sout_on_edge: assert property (
		$changed(serial_out_to_codecs_out) && serial_out_to_codecs_oe_out |-> $changed(link_bit_clock_out))
		else $error("serial out moved off a bit clock edge");
	a_rx_one_cycle: assert property (
		rx_valid_out |=> !rx_valid_out) else $error("rx pulse too long");
	a_rx_word_gap: assert property (
		rx_valid_out |-> (##128 rx_valid_out) or (##160 rx_valid_out) or (##[1:160] !codec_link_reset_n_out))
		else $error("rx word spacing wrong");
endmodule // actl_tdm_link_chk

bind actl_tdm_link actl_tdm_link_chk actl_tdm_link_chk_i (.clk_in, .rst_n_in, .codec_link_reset_n_out,
	.link_bit_clock_out, .frame_sync_out, .serial_out_to_codecs_out, .serial_out_to_codecs_oe_out, .rx_valid_out);

/* testbench/actl_codec_model.sv */
// three codecs answering on the serial inputs of the link
// assumes bit clock, frame sync and codec reset come from the host
module actl_codec_model (
	input wire clk_in, // bench clock, watches the bit clock
	input wire link_bit_clock_in, // bit clock
	input wire frame_sync_in, // frame sync
	input wire codec_link_reset_n_in, // codec reset
	output logic [2:0] serial_in_from_codecs_out // data towards host
);
	timeunit 1ns;
	timeprecision 1ns;
	logic bclk_ff, sync_ff;
	logic [8:0] bit_ff, n;
	logic [15:0] wd;
	initial serial_in_from_codecs_out = 3'h5;
	function automatic logic [15:0] cw(input logic [3:0] k, input logic [4:0] w);
		return {4'h5 + k, 7'h4B, w};
	endfunction
	always @(posedge clk_in) begin
		// a rise on the edge that lifts the codec reset is not a bit period of the host
		bclk_ff <= link_bit_clock_in | !codec_link_reset_n_in;
		if (!codec_link_reset_n_in) begin
			sync_ff <= frame_sync_in;
			bit_ff <= 9'h1F3;
			serial_in_from_codecs_out <= ~serial_in_from_codecs_out;
		end else if (link_bit_clock_in && !bclk_ff) begin
			sync_ff <= frame_sync_in;
			n = (frame_sync_in && !sync_ff && bit_ff > 9'h007) || bit_ff == 9'h1F3 ? 9'h000 : bit_ff + 9'h001;
			bit_ff <= n;
			for (int k = 0; k < 3; k++) begin
				wd = cw(k[3:0], n[8:4]);
				serial_in_from_codecs_out[k] <= n < 9'h1F0 ? wd[4'hF - n[3:0]] : ~serial_in_from_codecs_out[k];
			end
		end
	end
endmodule // actl_codec_model

/* testbench/actl_tdm_link_tb.sv */
// bench for the codec tdm link: clock, reset, scenarios, verdict
// assumes the codec model on the far side and the bound checker
module actl_tdm_link_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0, rst_n_in = 1'b0, link_en_in = 1'b1, tx_valid_in = 1'b0, bc1, bc2;
	logic [3:0] stream_num_in = 4'h9;
	logic [15:0] tx_data_in = 16'h0000;
	logic [63:0] tx_sh;
	logic [9:0] sy_sh;
	wire tx_ready_out, rx_valid_out, strap_out, codec_link_reset_n_out, link_bit_clock_out, frame_sync_out;
	wire serial_out_to_codecs_out, serial_out_to_codecs_oe_out;
	wire [47:0] rx_data_out;
	wire [2:0] serial_in_from_codecs_in;
	// pin with its pull-up; the carrier never forces it
	wire sout_pin = serial_out_to_codecs_oe_out ? serial_out_to_codecs_out : 1'b1;
	int fails = 0, comparisons = 0;
	time tags[$];
	actl_tdm_link actl_tdm_link_i (.clk_in, .rst_n_in, .link_en_in, .stream_num_in, .tx_data_in, .tx_valid_in,
		.tx_ready_out, .rx_data_out, .rx_valid_out, .strap_out, .codec_link_reset_n_out, .link_bit_clock_out,
		.frame_sync_out, .serial_out_to_codecs_out, .serial_out_to_codecs_oe_out,
		.serial_out_to_codecs_in(sout_pin), .serial_in_from_codecs_in);
	actl_codec_model actl_codec_model_i (.clk_in, .link_bit_clock_in(link_bit_clock_out),
		.frame_sync_in(frame_sync_out), .codec_link_reset_n_in(codec_link_reset_n_out),
		.serial_in_from_codecs_out(serial_in_from_codecs_in));
	initial forever #25 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////
	// serial out sampled on every bit clock edge, frame sync on each rise only, a little after it
	always @(negedge clk_in) begin
		bc1 <= link_bit_clock_out;
		bc2 <= bc1;
		if (bc1 !== bc2) tx_sh <= {tx_sh[62:0], sout_pin};
		if (bc1 && !bc2) begin
			sy_sh <= {sy_sh[8:0], frame_sync_out};
			if ({sy_sh[8:0], frame_sync_out} === {1'b0, 4'hF, stream_num_in, 1'b0}) tags.push_back($time);
		end
	end
	function automatic logic [15:0] cw(input logic [3:0] k, input logic [4:0] w);
		return {4'h5 + k, 7'h4B, w};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_hold; // codec reset window and strap capture
		int n;
		chk({codec_link_reset_n_out, serial_out_to_codecs_oe_out}, 2'h0);
		for (n = 0; n < 40 && codec_link_reset_n_out !== 1'b1; n++) @(negedge clk_in);
		chk(n > 15 && n < 25, 1'b1);
		chk(strap_out, 1'b1);
		@(negedge clk_in);
		chk(serial_out_to_codecs_oe_out, 1'b1);
	endtask
	task automatic t_sync; // frame marker with stream tag, frame period
		int n;
		tags.delete();
		for (n = 0; n < 10000 && tags.size() < 2; n++) @(negedge clk_in);
		chk(tags.size(), 2);
		chk(tags[1] - tags[0], 200000);
	endtask
	task automatic t_tx; // four words back to back, refusal while full
		logic [15:0] w[4] = '{16'hA5C3, 16'h3CF1, 16'h9E07, 16'h6B5A};
		int i, n, low;
		low = 0;
		for (i = 0; i < 4; i++) begin
			tx_data_in = w[i];
			tx_valid_in = 1'b1;
			for (n = 0; n < 200 && tx_ready_out !== 1'b1; n++) @(negedge clk_in);
			@(negedge clk_in);
			low += n;
		end
		tx_valid_in = 1'b0;
		chk(low > 0, 1'b1);
		for (n = 0; n < 3000 && tx_sh !== {w[0], w[1], w[2], w[3]}; n++) @(negedge clk_in);
		chk(tx_sh, {w[0], w[1], w[2], w[3]});
	endtask
	task automatic t_rx; // ten word groups, codecs 2,1,0 in order
		logic [4:0] w;
		int i, n;
		for (i = 0; i < 10; i++) begin
			for (n = 0; n < 200 && rx_valid_out !== 1'b1; n++) @(negedge clk_in);
			if (i == 0) w = rx_data_out[4:0];
			chk(rx_data_out, {cw(4'h2, w), cw(4'h1, w), cw(4'h0, w)});
			w = w == 5'h1E ? 5'h00 : w + 5'h01;
			@(negedge clk_in);
		end
	endtask
	task automatic t_dis; // link switched off in mid-frame, then on
		link_en_in = 1'b0;
		repeat (2) @(negedge clk_in);
		link_en_in = 1'b1;
		t_hold();
	endtask
	task automatic wrap_up;
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk_in);
		rst_n_in = 1'b1;
		@(negedge clk_in);
		t_hold();
		t_sync();
		t_tx();
		t_rx();
		t_dis();
		t_rx();
		wrap_up();
	end
	initial begin
		#3000000;
		fails++;
		wrap_up();
	end
endmodule // actl_tdm_link_tb
